// ---- rtl/mbio_map.svh ----
// register offsets, function and exception codes, frame positions and timing for the request handler
`ifndef MBIO_MAP_SVH
`define MBIO_MAP_SVH
// ==========================================================================
// register map
`define MBIO_REG_OUT_STATUS  16'h03E9
`define MBIO_REG_PULSE_MASK  16'h0A8C
`define MBIO_REG_PULSE_DUR   16'h0A8D
`define MBIO_PULSE_REGS      16'h0002
// ==========================================================================
// function codes
`define MBIO_FC_READ_HOLD    8'h03
`define MBIO_FC_READ_INPUT   8'h04
`define MBIO_FC_FORCE_COIL   8'h05
`define MBIO_FC_WRITE_MULTI  8'h10
`define MBIO_FC_ERROR        8'h81
// ==========================================================================
// exception codes
`define MBIO_EXC_NONE        8'h00
`define MBIO_EXC_ILL_FUNC    8'h01
`define MBIO_EXC_ILL_ADDR    8'h02
`define MBIO_EXC_ILL_VALUE   8'h03
`define MBIO_EXC_DEV_FAIL    8'h04
`define MBIO_EXC_GW_NO_REPLY 8'h11
// ==========================================================================
// value encodings
`define MBIO_COIL_ON         16'hFF00
`define MBIO_COIL_OFF        16'h0000
`define MBIO_UNIT_BROADCAST  8'h00
`define MBIO_PROTO_ID        16'h0000
// ==========================================================================
// frame byte positions and lengths
`define MBIO_HDR_BYTES       16'h0007
`define MBIO_FC_POS          16'h0007
`define MBIO_DATA_POS        16'h0008
`define MBIO_LEN_BASE        16'h0006
`define MBIO_FIXED_DATA      16'h0004
`define MBIO_MULTI_HDR       16'h0005
`define MBIO_EXC_LEN         16'h0003
`define MBIO_READ_LEN        16'h0003
`define MBIO_D_ADDR          0
`define MBIO_D_QTY           2
`define MBIO_D_BC            4
`define MBIO_D_VAL0          5
`define MBIO_D_VAL1          7
`define MBIO_DATA_MIN        9
// ==========================================================================
// timing and limits
`define MBIO_CLK_HZ          25000000
`define MBIO_US_PER_S        1000000
`define MBIO_PULSE_UNIT_US   1000
`define MBIO_MAX_READ        16
`define MBIO_READ_LIMIT      125
`define MBIO_NUM_TERM        16
`endif

// ---- rtl/mbio_pkg.sv ----
// types shared by the request handler and its pulse timer
package mbio_pkg;
  // ==========================================================================
  // handler states
  typedef enum logic [1:0] {ST_RECV, ST_EXEC, ST_SEND} mbio_state_e;
  // one byte of a request or response stream
  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } mbio_beat_s;
  // fixed seven-byte frame header, first byte in the top bits
  typedef struct packed {
    logic [15:0] tid;
    logic [15:0] pid;
    logic [15:0] len;
    logic [7:0]  unit;
  } mbio_hdr_s;
  typedef logic [15:0] mbio_word_t;
endpackage

// ---- rtl/mbio_pulse_timer.sv ----
// millisecond countdown that holds busy for the programmed pulse duration
`timescale 1ns/1ps
module mbio_pulse_timer #(
  parameter int CYC_PER_MS = 25000,
  parameter int DUR_W      = 16
) (
  input  wire logic             clock,  // system clock
  input  wire logic             rst_n,  // synchronous reset, active low
  input  wire logic             start,  // one-cycle pulse: (re)load duration
  input  wire logic [DUR_W-1:0] dur_ms, // duration in milliseconds
  output logic                  busy    // high while the pulse runs
);
  import mbio_pkg::*;
  localparam int PW = $clog2(CYC_PER_MS);
  localparam logic [PW-1:0] PRE_TOP = PW'(CYC_PER_MS - 1);

  if (CYC_PER_MS < 2) begin : g_bad_rate
    $error("pulse timer needs at least two cycles per millisecond");
  end

  logic [PW-1:0]    pre_reg;
  logic [DUR_W-1:0] ms_reg;

  // ==========================================================================
  // prescaler and millisecond counter; a new start restarts the pulse
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pre_reg <= '0;
      ms_reg  <= '0;
    end else if (start) begin
      pre_reg <= PRE_TOP;
      ms_reg  <= dur_ms;
    end else if (ms_reg != '0) begin
      if (pre_reg == '0) begin
        pre_reg <= PRE_TOP;
        ms_reg  <= ms_reg - 1'b1;
      end else begin
        pre_reg <= pre_reg - 1'b1;
      end
    end
  end

  assign busy = (ms_reg != '0);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // a restart with zero duration may cut a pulse short on purpose, so only a natural end is checked
  a_pulse_end: assert property ($fell(busy) && !$past(start) |-> $past(pre_reg) == '0 && $past(ms_reg) == 1)
    else $error("pulse ended before its last millisecond ran out");
  a_pulse_load: assert property (start && dur_ms != '0 |=> busy && ms_reg == $past(dur_ms))
    else $error("pulse did not start with the requested duration");
endmodule

// ---- rtl/mbio_handler.sv ----
// request handler for a sixteen-terminal remote I/O node on a byte-stream TCP payload
`timescale 1ns/1ps
`include "mbio_map.svh"
// Behaviour
// - reading the output status register returns bit n as terminal n's drive state
// - coil address 0 selects terminal 0, each next address the next terminal
// - force coil value FF00 turns the output on, 0000 turns it off
// - a good force coil reply echoes function, coil address and value
// - input register reads use the holding read layout, other code and data space
// - an unavailable function is answered with error function 81 and code 01
// - code 01 also covers a multiple-register write sent to the broadcast unit
// - code 02 when start register and count do not fit the map
// - code 03 for a bad data value or a wrong implied length
// - code 04 when the action itself fails
// - code 11 in gateway mode when the target gave no reply
// - a pulse is written as terminal mask, then duration in ms; either register alone also starts one
// - mask bit n selects terminal n for pulsing
// - a good multiple-register write is answered with a copy of the request
// - the transaction identifier is copied unchanged into the reply header
// - every 16-bit value and address travels high byte first
module mbio_handler #(
  parameter int CYC_PER_MS  = (`MBIO_CLK_HZ / `MBIO_US_PER_S) * `MBIO_PULSE_UNIT_US,
  parameter int MAX_READ    = `MBIO_MAX_READ,
  parameter int RX_DATA_MAX = `MBIO_DATA_MIN
) (
  input  wire logic               CLOCK,                   // 25 MHz system clock
  input  wire logic               RST_N,                   // synchronous reset, active low
  input  wire logic               RX_VALID,                // request byte offered
  output logic                    RX_READY,                // request byte taken
  input  wire mbio_pkg::mbio_beat_s RX_BEAT,               // request byte and end of frame
  output logic                    TX_VALID,                // response byte offered
  input  wire logic               TX_READY,                // response byte taken
  output mbio_pkg::mbio_beat_s    TX_BEAT,                 // response byte and end of frame
  input  wire logic [15:0]        IO_IN,                   // sensed terminal inputs
  output logic [15:0]             IO_OUT,                  // driven terminal outputs
  output logic                    PULSE_BUSY,              // a terminal pulse is running
  input  wire logic               EXEC_FAULT,              // the action cannot be carried out
  input  wire logic               GW_MODE,                 // node acts as a gateway
  input  wire logic               GATEWAY_TARGET_NO_REPLY  // target behind gateway is silent
);
  import mbio_pkg::*;

  localparam int DIW = $clog2(RX_DATA_MAX);
  localparam int TW  = $clog2(`MBIO_NUM_TERM);
  localparam int HW  = $bits(mbio_hdr_s);

  if (MAX_READ < 1 || MAX_READ > `MBIO_READ_LIMIT || RX_DATA_MAX < `MBIO_DATA_MIN) begin : g_bad_cfg
    $error("read limit or request buffer size out of range");
  end

  mbio_state_e      state_reg;
  logic [HW-1:0]    hdr_sr_reg;
  mbio_hdr_s        hdr;
  logic [7:0]       fc_reg;
  logic [7:0]       data_mem [RX_DATA_MAX];
  logic [15:0]      rx_cnt_reg;
  logic [15:0]      frame_cnt_reg;
  logic [15:0]      tx_idx_reg;
  logic [7:0]       exc_reg;
  logic [7:0]       exc_next;
  mbio_beat_s       tx_beat_reg;
  mbio_word_t       out_reg;
  mbio_word_t       io_out_reg;
  mbio_word_t       pulse_mask_reg;
  mbio_word_t       pulse_dur_reg;
  mbio_word_t       pulse_act_reg;
  logic             pulse_busy;
  logic             pulse_start;
  logic             rx_take;
  logic             tx_take;
  logic             exec_ok;
  logic             is_read;
  logic             fc_known;
  logic             gw_fail;
  logic             len_ok;
  logic             map_ok;
  mbio_word_t       d_addr;
  mbio_word_t       d_qty;
  logic [7:0]       d_bc;
  mbio_word_t       d_w0;
  mbio_word_t       d_w1;
  logic [15:0]      data_cnt;
  logic [15:0]      resp_len;
  logic [15:0]      resp_total;
  logic [HW-1:0]    resp_hdr;
  mbio_word_t       new_mask;
  mbio_word_t       new_dur;

  // ==========================================================================
  // stream handshakes: one request is received, executed and answered at a time
  assign RX_READY = (state_reg == ST_RECV);
  assign TX_VALID = (state_reg == ST_SEND);
  assign rx_take  = RX_VALID && RX_READY;
  assign tx_take  = TX_VALID && TX_READY;
  assign TX_BEAT  = tx_beat_reg;
  assign IO_OUT   = io_out_reg;
  assign PULSE_BUSY = pulse_busy;

  // request fields, high byte first
  assign hdr      = mbio_hdr_s'(hdr_sr_reg);
  assign d_addr   = {data_mem[`MBIO_D_ADDR], data_mem[`MBIO_D_ADDR + 1]};
  assign d_qty    = {data_mem[`MBIO_D_QTY], data_mem[`MBIO_D_QTY + 1]};
  assign d_bc     = data_mem[`MBIO_D_BC];
  assign d_w0     = {data_mem[`MBIO_D_VAL0], data_mem[`MBIO_D_VAL0 + 1]};
  assign d_w1     = {data_mem[`MBIO_D_VAL1], data_mem[`MBIO_D_VAL1 + 1]};
  assign data_cnt = frame_cnt_reg - `MBIO_DATA_POS;
  assign len_ok   = (hdr.len == frame_cnt_reg - `MBIO_LEN_BASE);

  // ==========================================================================
  // frame state machine
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state_reg <= ST_RECV;
    end else begin
      unique case (state_reg)
        ST_RECV: begin
          // runt frames and foreign protocol ids are dropped without a reply
          if (rx_take && RX_BEAT.last && rx_cnt_reg >= `MBIO_FC_POS && hdr.pid == `MBIO_PROTO_ID) begin
            state_reg <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state_reg <= ST_SEND;
        end
        ST_SEND: begin
          if (tx_take && tx_beat_reg.last) begin
            state_reg <= ST_RECV;
          end
        end
      endcase
    end
  end

  // byte counting; the count of the finished frame is kept for the length checks
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rx_cnt_reg    <= 16'h0000;
      frame_cnt_reg <= 16'h0000;
    end else if (rx_take) begin
      rx_cnt_reg <= RX_BEAT.last ? 16'h0000 : rx_cnt_reg + 16'h0001;
      if (RX_BEAT.last) begin
        frame_cnt_reg <= rx_cnt_reg + 16'h0001;
      end
    end
  end

  // header shifts in, then the function code, then data bytes up to the buffer size;
  // longer frames are still counted, so they fail the length check instead of overrunning
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      hdr_sr_reg <= '0;
      fc_reg     <= 8'h00;
    end else if (rx_take) begin
      if (rx_cnt_reg < `MBIO_HDR_BYTES) begin
        hdr_sr_reg <= {hdr_sr_reg[HW-9:0], RX_BEAT.data};
      end else if (rx_cnt_reg == `MBIO_FC_POS) begin
        fc_reg <= RX_BEAT.data;
      end
    end
  end

  // data buffer, no reset needed: only bytes of the current frame are ever read back
  always_ff @(posedge CLOCK) begin
    if (rx_take && rx_cnt_reg >= `MBIO_DATA_POS && rx_cnt_reg - `MBIO_DATA_POS < 16'(RX_DATA_MAX)) begin
      data_mem[DIW'(rx_cnt_reg - `MBIO_DATA_POS)] <= RX_BEAT.data;
    end
  end

  // ==========================================================================
  // request checks, in priority order
  assign is_read  = (fc_reg == `MBIO_FC_READ_HOLD) || (fc_reg == `MBIO_FC_READ_INPUT);
  assign fc_known = is_read || (fc_reg == `MBIO_FC_FORCE_COIL) || (fc_reg == `MBIO_FC_WRITE_MULTI);
  assign gw_fail  = GW_MODE && GATEWAY_TARGET_NO_REPLY;
  // holding space: status word alone, the pulse pair from the mask register, or either pulse register alone
  assign map_ok   = (d_addr == `MBIO_REG_OUT_STATUS && d_qty == 16'h0001) ||
                    (d_addr == `MBIO_REG_PULSE_MASK && d_qty <= `MBIO_PULSE_REGS) ||
                    (d_addr == `MBIO_REG_PULSE_DUR && d_qty == 16'h0001);

  always_comb begin
    exc_next = `MBIO_EXC_NONE;
    if (gw_fail) begin
      exc_next = `MBIO_EXC_GW_NO_REPLY;
    end else if (!fc_known) begin
      exc_next = `MBIO_EXC_ILL_FUNC;
    end else if (fc_reg == `MBIO_FC_WRITE_MULTI && hdr.unit == `MBIO_UNIT_BROADCAST) begin
      exc_next = `MBIO_EXC_ILL_FUNC;
    end else if (!len_ok) begin
      exc_next = `MBIO_EXC_ILL_VALUE;
    end else if (fc_reg == `MBIO_FC_WRITE_MULTI) begin
      if (d_qty == 16'h0000 || d_qty > `MBIO_PULSE_REGS || {8'h00, d_bc} != {d_qty[14:0], 1'b0} ||
          data_cnt != `MBIO_MULTI_HDR + {8'h00, d_bc}) begin
        exc_next = `MBIO_EXC_ILL_VALUE;
      end else if (!map_ok) begin
        exc_next = `MBIO_EXC_ILL_ADDR;
      end
    end else if (data_cnt != `MBIO_FIXED_DATA) begin
      exc_next = `MBIO_EXC_ILL_VALUE;
    end else if (is_read && (d_qty == 16'h0000 || d_qty > 16'(MAX_READ))) begin
      exc_next = `MBIO_EXC_ILL_VALUE;
    end else if (fc_reg == `MBIO_FC_READ_HOLD && !map_ok) begin
      exc_next = `MBIO_EXC_ILL_ADDR;
    end else if (fc_reg != `MBIO_FC_READ_HOLD && {1'b0, d_addr} + {1'b0, (is_read ? d_qty : 16'h0001)} >
                 17'(`MBIO_NUM_TERM)) begin
      exc_next = `MBIO_EXC_ILL_ADDR;
    end else if (fc_reg == `MBIO_FC_FORCE_COIL && d_qty != `MBIO_COIL_ON && d_qty != `MBIO_COIL_OFF) begin
      exc_next = `MBIO_EXC_ILL_VALUE;
    end
    // a failure is only reported for a request that was otherwise acceptable
    if (exc_next == `MBIO_EXC_NONE && EXEC_FAULT) begin
      exc_next = `MBIO_EXC_DEV_FAIL;
    end
  end

  assign exec_ok = (state_reg == ST_EXEC) && (exc_next == `MBIO_EXC_NONE);

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      exc_reg <= `MBIO_EXC_NONE;
    end else if (state_reg == ST_EXEC) begin
      exc_reg <= exc_next;
    end
  end

  // ==========================================================================
  // effects of an accepted write; the status register write sets all outputs at once
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      out_reg <= 16'h0000;
    end else if (exec_ok && fc_reg == `MBIO_FC_FORCE_COIL) begin
      out_reg[d_addr[TW-1:0]] <= (d_qty == `MBIO_COIL_ON);
    end else if (exec_ok && fc_reg == `MBIO_FC_WRITE_MULTI && d_addr == `MBIO_REG_OUT_STATUS) begin
      out_reg <= d_w0;
    end
  end

  // pulse registers: a write to either one starts a pulse with the merged values
  assign new_mask = (d_addr == `MBIO_REG_PULSE_MASK) ? d_w0 : pulse_mask_reg;
  assign new_dur  = (d_addr == `MBIO_REG_PULSE_MASK && d_qty == `MBIO_PULSE_REGS) ? d_w1 :
                    (d_addr == `MBIO_REG_PULSE_DUR) ? d_w0 : pulse_dur_reg;
  assign pulse_start = exec_ok && fc_reg == `MBIO_FC_WRITE_MULTI && d_addr != `MBIO_REG_OUT_STATUS;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      pulse_mask_reg <= 16'h0000;
      pulse_dur_reg  <= 16'h0000;
      pulse_act_reg  <= 16'h0000;
    end else if (pulse_start) begin
      pulse_mask_reg <= new_mask;
      pulse_dur_reg  <= new_dur;
      pulse_act_reg  <= new_mask;
    end
  end

  mbio_pulse_timer #(
    .CYC_PER_MS (CYC_PER_MS),
    .DUR_W      ($bits(mbio_word_t))
  ) u_pulse (
    .clock  (CLOCK),
    .rst_n  (RST_N),
    .start  (pulse_start),
    .dur_ms (new_dur),
    .busy   (pulse_busy)
  );

  // drive register: pulsed terminals are forced on only while the timer runs
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      io_out_reg <= 16'h0000;
    end else begin
      io_out_reg <= out_reg | (pulse_busy ? pulse_act_reg : 16'h0000);
    end
  end

  // ==========================================================================
  // response assembly, one byte at a time, nothing buffered
  function automatic mbio_word_t read_word(input logic [15:0] a);
    read_word = 16'h0000;
    if (fc_reg == `MBIO_FC_READ_INPUT) begin
      if (a < 16'(`MBIO_NUM_TERM)) begin
        read_word = IO_IN[a[TW-1:0]] ? `MBIO_COIL_ON : `MBIO_COIL_OFF;
      end
    end else if (a == `MBIO_REG_OUT_STATUS) begin
      read_word = io_out_reg;
    end else if (a == `MBIO_REG_PULSE_MASK) begin
      read_word = pulse_mask_reg;
    end else if (a == `MBIO_REG_PULSE_DUR) begin
      read_word = pulse_dur_reg;
    end
  endfunction

  assign resp_len   = (exc_reg != `MBIO_EXC_NONE) ? `MBIO_EXC_LEN :
                      is_read ? `MBIO_READ_LEN + {d_qty[14:0], 1'b0} : hdr.len;
  assign resp_total = `MBIO_LEN_BASE + resp_len;
  assign resp_hdr   = {hdr.tid, `MBIO_PROTO_ID, resp_len, hdr.unit};

  function automatic logic [7:0] resp_byte(input logic [15:0] i);
    logic [15:0] k;
    mbio_word_t  w;
    k = i - `MBIO_DATA_POS - 16'h0001;
    w = read_word(d_addr + {1'b0, k[15:1]});
    if (i < `MBIO_HDR_BYTES) begin
      resp_byte = resp_hdr[(int'(`MBIO_HDR_BYTES) - 1 - int'(i)) * 8 +: 8];
    end else if (i == `MBIO_FC_POS) begin
      resp_byte = (exc_reg != `MBIO_EXC_NONE) ? `MBIO_FC_ERROR : fc_reg;
    end else if (exc_reg != `MBIO_EXC_NONE) begin
      resp_byte = exc_reg;
    end else if (is_read && i == `MBIO_DATA_POS) begin
      resp_byte = {d_qty[6:0], 1'b0};
    end else if (is_read) begin
      resp_byte = k[0] ? w[7:0] : w[15:8];
    end else begin
      // force coil and multiple write both answer with the request's own data
      resp_byte = data_mem[DIW'(i - `MBIO_DATA_POS)];
    end
  endfunction

  // output byte register; the first byte is the transaction id, known before the checks settle
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      tx_idx_reg  <= 16'h0000;
      tx_beat_reg <= '0;
    end else if (state_reg == ST_EXEC) begin
      tx_idx_reg  <= 16'h0000;
      tx_beat_reg <= '{last: 1'b0, data: resp_byte(16'h0000)};
    end else if (tx_take && !tx_beat_reg.last) begin
      tx_idx_reg  <= tx_idx_reg + 16'h0001;
      tx_beat_reg <= '{last: (tx_idx_reg + 16'h0002 == resp_total), data: resp_byte(tx_idx_reg + 16'h0001)};
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  sequence s_exec;
    state_reg == ST_EXEC && !gw_fail;
  endsequence
  sequence s_answer_start;
    ##1 state_reg == ST_SEND && tx_idx_reg == 16'h0000;
  endsequence

  a_tid_echo: assert property (s_exec |-> s_answer_start ##0 TX_BEAT.data == hdr.tid[15:8])
    else $error("reply does not open with the request transaction id");
  a_gw_code: assert property (state_reg == ST_EXEC && gw_fail |=> exc_reg == `MBIO_EXC_GW_NO_REPLY)
    else $error("silent gateway target not reported");
  a_bad_func: assert property (s_exec ##0 !fc_known |=> exc_reg == `MBIO_EXC_ILL_FUNC)
    else $error("unknown function not refused");
  // the sink may stall on the error function byte, so the code is only expected once that byte is taken
  a_err_fc: assert property (tx_take && tx_idx_reg == 16'h0006 && exc_reg != `MBIO_EXC_NONE
                             |=> TX_BEAT.data == `MBIO_FC_ERROR and (tx_take |=> TX_BEAT.data == exc_reg))
    else $error("error reply lacks error function and code");
  a_coil_force: assert property (exec_ok && fc_reg == `MBIO_FC_FORCE_COIL
                                 |=> out_reg[d_addr[TW-1:0]] == (d_qty == `MBIO_COIL_ON))
    else $error("forced coil did not take the requested value");
  a_coil_range: assert property (s_exec ##0 fc_reg == `MBIO_FC_FORCE_COIL && len_ok &&
                                 data_cnt == `MBIO_FIXED_DATA && d_addr >= 16'(`MBIO_NUM_TERM)
                                 |=> exc_reg == `MBIO_EXC_ILL_ADDR)
    else $error("coil beyond the last terminal not refused");
  a_echo_byte: assert property (TX_VALID && exc_reg == `MBIO_EXC_NONE && !is_read && tx_idx_reg >= `MBIO_DATA_POS
                                |-> TX_BEAT.data == data_mem[DIW'(tx_idx_reg - `MBIO_DATA_POS)])
    else $error("write reply differs from the request");
  a_status_word: assert property (!pulse_busy [*2] |-> IO_OUT == $past(out_reg))
    else $error("terminal drive does not follow the status word");
  // a restart changes the mask one cycle before the drive register follows, so that cycle is skipped
  a_pulse_apply: assert property (pulse_busy [*2] ##0 $stable(pulse_act_reg)
                                  |-> (IO_OUT & pulse_act_reg) == pulse_act_reg)
    else $error("masked terminal not driven during its pulse");
endmodule

// ---- testbench/mbio_master.sv ----
// behavioural supervisory master: sends request frames, takes reply bytes with stalls
`timescale 1ns/1ps
module mbio_master
  import mbio_pkg::*;
(
  input  wire logic  clock,    // system clock
  output logic       rx_valid, // request byte offered
  input  wire logic  rx_ready, // handler took the byte
  output mbio_beat_s rx_beat,  // request byte and end mark
  output logic       tx_ready  // reply byte taken
);
  // ==========================================================================
  // idle levels
  initial begin
    rx_valid = 1'b0;
    rx_beat  = '{last: 1'b0, data: 8'h00};
    tx_ready = 1'b0;
  end
  // stall about one cycle in four, so the handler must hold its reply byte
  always @(posedge clock) begin
    tx_ready <= ($urandom % 4) != 0;
  end
  // one frame in order, each byte held until taken; the released line shows the inverse
  task automatic send(input logic [7:0] b[$]);
    for (int i = 0; i < b.size(); i++) begin
      rx_valid <= 1'b1;
      rx_beat  <= '{last: (i == b.size() - 1), data: b[i]};
      do @(posedge clock); while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
    rx_beat  <= '{last: 1'b0, data: ~b[b.size() - 1]};
  endtask
endmodule

// ---- testbench/tb_top.sv ----
// self-checking bench for the request handler
`timescale 1ns/1ps
module tb_top;
  import mbio_pkg::*;
  localparam int CYC = 4;
  logic       clock = 0, rst_n = 0, exec_fault = 0, gw_mode = 0, no_reply = 0;
  logic       rx_valid, rx_ready, tx_valid, tx_ready, pulse_busy;
  mbio_beat_s rx_beat, tx_beat;
  logic [15:0] io_in = 0, io_out, tid = 16'h1234;
  logic [7:0]  req[$];
  logic [8:0]  exp_q[$];
  int          fail_count = 0, n_checks = 0, cyc = 0;
  logic [7:0]  xf[6] = '{8'h2B, 8'h03, 8'h05, 8'h05, 8'h03, 8'h05};
  logic [15:0] xa[6] = '{16'h0000, 16'h0100, 16'h0003, 16'h0003, 16'h03E9, 16'h0010};
  logic [15:0] xv[6] = '{16'h0001, 16'h0001, 16'h1234, 16'hFF00, 16'h0001, 16'hFF00};
  logic [2:0]  xl[6] = '{3'b000, 3'b000, 3'b000, 3'b001, 3'b110, 3'b000};
  logic [7:0]  xc[6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h11, 8'h02};
  // ==========================================================================
  // clock and instances
  always #20 clock = ~clock;
  mbio_handler #(.CYC_PER_MS(CYC)) uut (.CLOCK(clock), .RST_N(rst_n), .RX_VALID(rx_valid),
    .RX_READY(rx_ready), .RX_BEAT(rx_beat), .TX_VALID(tx_valid), .TX_READY(tx_ready),
    .TX_BEAT(tx_beat), .IO_IN(io_in), .IO_OUT(io_out), .PULSE_BUSY(pulse_busy),
    .EXEC_FAULT(exec_fault), .GW_MODE(gw_mode), .GATEWAY_TARGET_NO_REPLY(no_reply));
  mbio_master m (.clock(clock), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_beat(rx_beat),
    .tx_ready(tx_ready));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    n_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard well above the thousand or so cycles the tests need
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  // each taken reply byte is matched against the oldest note
  always @(posedge clock) begin
    if ((rst_n && tx_valid && tx_ready) === 1'b1) begin
      if (exp_q.size() == 0) check("tx_extra", 16'(tx_beat), 16'hFFFF);
      else check("tx_beat", 16'(tx_beat), 16'(exp_q.pop_front()));
    end
  end
  task automatic note(input logic [7:0] b, input logic l = 1'b0);
    exp_q.push_back({l, b});
  endtask
  task automatic hdr(input logic [7:0] len, input logic [7:0] unit);
    note(tid[15:8]); note(tid[7:0]); note(8'h00); note(8'h00); note(8'h00); note(len); note(unit);
  endtask
  task automatic mk(input logic [7:0] unit, fc, input logic [15:0] a, v);
    req = '{tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, 8'h06, unit, fc, a[15:8], a[7:0], v[15:8], v[7:0]};
  endtask
  task automatic mk16(input logic [7:0] unit, input logic [15:0] mask, dur);
    req = '{tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, 8'h0B, unit, 8'h10, 8'h0A, 8'h8C, 8'h00, 8'h02,
            8'h04, mask[15:8], mask[7:0], dur[15:8], dur[7:0]};
  endtask
  task automatic echo();
    foreach (req[i]) note(req[i], i == req.size() - 1);
  endtask
  task automatic xfer();
    int n;
    m.send(req);
    n = 0;
    while ((exp_q.size() != 0 || rx_ready !== 1'b1) && n < 300) begin
      @(posedge clock);
      n++;
    end
    check("reply_done", 16'(n < 300), 16'h0001);
    tid = tid + 16'h0101;
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(36));
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    mk(8'h04, 8'h05, 16'h0005, 16'hFF00); echo(); xfer();
    check("io_out", io_out, 16'h0020);
    mk(8'h04, 8'h03, 16'h03E9, 16'h0001); hdr(8'h05, 8'h04);
    note(8'h03); note(8'h02); note(8'h00); note(8'h20, 1'b1); xfer();
    io_in <= 16'($urandom);
    @(posedge clock);
    mk(8'h14, 8'h04, 16'h0000, 16'h0002); hdr(8'h07, 8'h14); note(8'h04); note(8'h04);
    note(io_in[0] ? 8'hFF : 8'h00); note(8'h00); note(io_in[1] ? 8'hFF : 8'h00); note(8'h00, 1'b1);
    xfer();
    $display("test reads and coil done");
    for (int i = 0; i < 6; i++) begin
      {gw_mode, no_reply, exec_fault} <= xl[i];
      @(posedge clock);
      mk(8'h04, xf[i], xa[i], xv[i]); hdr(8'h03, 8'h04); note(8'h81); note(xc[i], 1'b1);
      xfer();
    end
    {gw_mode, no_reply, exec_fault} <= 3'b000;
    mk16(8'h00, 16'h0050, 16'h0064); hdr(8'h03, 8'h00); note(8'h81); note(8'h01, 1'b1); xfer();
    $display("test exceptions done");
    mk16(8'h2C, 16'h0050, 16'h0064); echo(); xfer();
    check("pulse_busy", 16'(pulse_busy), 16'h0001);
    check("io_out_pulse", io_out, 16'h0070);
    repeat (100 * CYC) @(posedge clock);
    check("pulse_end", 16'(pulse_busy), 16'h0000);
    check("io_out_end", io_out, 16'h0020);
    $display("test pulse done");
    mk(8'h04, 8'h05, 16'h0005, 16'h0000); echo(); xfer();
    check("io_out_off", io_out, 16'h0000);
    $display("test coil off done");
    end_sim();
  end
endmodule
